//--- bench/status_byte_formatter_bench.sv
`timescale 1ns/1ps
module status_byte_formatter_bench;
   localparam int TC = 10;
   logic clk = 1'b0, sys_rst = 1'b1, new_value = 1'b1, vt_bad = 1'b0;
   logic crit = 1'b0, heat = 1'b0, dv = 1'b1, form, sv, ok;
   logic [7:0] n = 8'h00, cap = 8'h64, avg = 8'h02, td = 8'h00;
   status_fmt_pkg::status_bytes_t st, snap;
   int bad_count = 0, comparisons = 0, cycles = 0;

   status_byte_formatter #(.TICK_CYCLES(TC)) i_dut (
      .clk(clk), .sys_rst(sys_rst), .fill_count(n), .fill_capacity(cap),
      .averaging_time_param(avg), .new_value(new_value),
      .virtual_temperature_bad(vt_bad), .heat_criterion(crit),
      .heat_on(heat), .data_valid(dv), .tdiff_xy(td),
      .form_telegram(form), .status(st), .status_valid(sv));
   status_logger i_logger (.clk(clk), .form_telegram(form), .status(st),
      .status_valid(sv));

   always #2 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         wrap_up();
      end
   end

   task automatic check(input string what, input logic [23:0] seen,
                        input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // expected bytes worked out from current inputs and error bits
   function automatic logic [23:0] exp_bytes(input logic [7:0] err);
      logic [2:0] k;
      logic [1:0] tc, fc;
      k = 3'h0;
      for (int i = 1; i <= 7; i++) if (8 * n > i * cap) k = i[2:0];
      tc = (td <= 31) ? 2'h0 : (td <= 63) ? 2'h1 : (td <= 79) ? 2'h2 : 2'h3;
      fc = (100 * n > 80 * cap) ? 2'h0 : (100 * n > 66 * cap) ? 2'h1 :
           (100 * n > 33 * cap) ? 2'h2 : 2'h3;
      return {1'b0, heat, crit, 1'b0, k, 1'b0, err,
              heat, 2'b10, fc, tc, ~dv};
   endfunction : exp_bytes

   task automatic sample(input string what, input logic [7:0] err);
      i_logger.poll(snap, ok);
      check("valid pulse", {23'h0, ok}, 24'h1);
      check(what, snap, exp_bytes(err));
   endtask : sample

   task automatic wait_cycles(input int c);
      repeat (c) @(posedge clk);
   endtask : wait_cycles

   task automatic sc_table;
      logic [7:0] counts [8] = '{8'h01, 8'h0c, 8'h0d, 8'h21, 8'h32, 8'h43,
                                 8'h50, 8'h64};
      logic [7:0] diffs [8] = '{8'h00, 8'h1f, 8'h20, 8'h3f, 8'h40, 8'h4f,
                                8'h50, 8'hff};
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         #1 n = counts[i];
         td = diffs[i];
         {crit, heat, dv} = i[2:0];
         sample("table", 8'h00);
      end
      sample("bands", 8'h00);
   endtask : sc_table

   task automatic sc_half;
      @(posedge clk);
      #1 avg = 8'h0a;
      n = 8'h04;
      sample("below half", 8'h01);
      n = 8'h05;
      sample("half held", 8'h00);
      avg = 8'h09;
      n = 8'h00;
      sample("short average", 8'h00);
   endtask : sc_half

   task automatic sc_timeout;
      @(posedge clk);
      #1 new_value = 1'b0;
      wait_cycles(8 * TC);
      sample("early", 8'h00);
      wait_cycles(4 * TC);
      sample("no values", 8'h01);
      new_value = 1'b1;
      sample("values back", 8'h00);
   endtask : sc_timeout

   task automatic sc_static;
      @(posedge clk);
      #1 vt_bad = 1'b1;
      wait_cycles(55 * TC);
      sample("one minute", 8'h00);
      wait_cycles(10 * TC);
      sample("lasting fault", 8'h02);
      vt_bad = 1'b0;
      sample("fault gone", 8'h00);
   endtask : sc_static

   task automatic wrap_up;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up

   initial begin
      wait_cycles(12);
      #1 sys_rst = 1'b0;
      check("reset bytes", st, 24'h000040);
      sc_table();
      sc_half();
      sc_timeout();
      sc_static();
      wrap_up();
   end
endmodule : status_byte_formatter_bench

//--- bench/status_logger.sv
`timescale 1ns/1ps
module status_logger (
   input  wire logic                          clk,
   output logic                               form_telegram,
   input  wire status_fmt_pkg::status_bytes_t status,
   input  wire logic                          status_valid
);
   initial form_telegram = 1'b0;

   // one strobe, one snapshot; ok only if the valid pulse is one cycle
   task automatic poll(output status_fmt_pkg::status_bytes_t snap,
                       output logic ok);
      @(posedge clk);
      #1 form_telegram = 1'b1;
      @(posedge clk);
      #1 form_telegram = 1'b0;
      snap = status;
      ok = status_valid;
      @(posedge clk);
      #1 ok = ok & ~status_valid;
   endtask : poll
endmodule : status_logger

//--- core/sec_timer.sv
`timescale 1ns/1ps
module sec_timer #(
   parameter int LIMIT = status_fmt_pkg::TIMEOUT_SEC
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic tick,
   input  wire logic restart,
   output logic      expired
);
   logic [7:0] secs;
   logic [7:0] next_secs;
   logic       next_expired;

   // expired on the LIMIT-th tick counted while the condition has held
   always_comb begin
      next_secs    = secs;
      next_expired = expired;
      if (restart) begin
         next_secs    = '0;
         next_expired = 1'b0;
      end else if (tick && !expired) begin
         next_secs = secs + 8'h1;
         if (secs >= 8'(LIMIT - 1))
            next_expired = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         secs    <= '0;
         expired <= 1'b0;
      end else begin
         secs    <= next_secs;
         expired <= next_expired;
      end
   end
endmodule : sec_timer

//--- core/second_tick.sv
`timescale 1ns/1ps
module second_tick #(
   parameter int CYCLES = status_fmt_pkg::TICK_CYCLES
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   output logic      tick
);
   logic [31:0] count;
   logic [31:0] next_count;
   logic        next_tick;

   always_comb begin
      next_tick  = 1'b0;
      next_count = count + 32'h1;
      if (count >= 32'(CYCLES - 1)) begin
         next_count = '0;
         next_tick  = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count <= '0;
         tick  <= 1'b0;
      end else begin
         count <= next_count;
         tick  <= next_tick;
      end
   end
endmodule : second_tick

//--- core/status_byte_formatter.sv
`timescale 1ns/1ps
// Function
// RULE1 - operating bits 3:1 hold code k where k/8 < fill <= (k+1)/8.
// RULE2 - operating bits 0, 4 and 7 are always zero.
// RULE3 - operating bit 5 mirrors the heating switch-on criterion.
// RULE4 - operating bit 6 mirrors the heating-on state.
// RULE5 - below 10 s averaging, error bit 0 sets after 10 s without values.
// RULE6 - at 10 s or more, error bit 0 sets when fewer than half are held.
// RULE7 - error bit 1 sets when a malfunction lasts longer than one minute.
// RULE8 - error bits 7:2 are always zero.
// RULE9 - telegram 9 bit 0 is one when the data are invalid.
// RULE10 - telegram 9 bits 2:1 code the X/Y temperature difference.
// RULE11 - telegram 9 bits 4:3 code the buffer fill level in four bands.
// RULE12 - telegram 9 bit 5 is zero, bit 6 one, bit 7 the heating-on state.
// RULE13 - the averaging time selects the general malfunction criterion.
// RULE14 - all three bytes are captured together on one telegram strobe.
module status_byte_formatter #(
   parameter int TICK_CYCLES = status_fmt_pkg::TICK_CYCLES,
   parameter int FILL_W      = status_fmt_pkg::FILL_W,
   parameter int TEMP_W      = status_fmt_pkg::TEMP_W
) (
   input  wire logic                         clk,
   input  wire logic                         sys_rst,
   input  wire logic [FILL_W-1:0]            fill_count,
   input  wire logic [FILL_W-1:0]            fill_capacity,
   input  wire logic [7:0]                   averaging_time_param,
   input  wire logic                         new_value,
   input  wire logic                         virtual_temperature_bad,
   input  wire logic                         heat_criterion,
   input  wire logic                         heat_on,
   input  wire logic                         data_valid,
   input  wire logic [TEMP_W-1:0]            tdiff_xy,
   input  wire logic                         form_telegram,
   output status_fmt_pkg::status_bytes_t     status,
   output logic                              status_valid
);
   logic tick;
   logic no_value_exp;
   logic static_exp;
   logic gen_fault;
   logic static_cond;
   logic [2:0] fill_code;
   logic [1:0] tdiff_code;
   logic [1:0] band_code;
   logic [FILL_W+7:0] count_x100;
   logic [FILL_W+7:0] cap_x80;
   logic [FILL_W+7:0] cap_x66;
   logic [FILL_W+7:0] cap_x33;
   status_fmt_pkg::status_bytes_t next_status;
   logic next_status_valid;

   second_tick #(.CYCLES(TICK_CYCLES)) u_tick (
      .clk     (clk),
      .sys_rst (sys_rst),
      .tick    (tick)
   );

   sec_timer #(.LIMIT(status_fmt_pkg::TIMEOUT_SEC)) u_noval (
      .clk     (clk),
      .sys_rst (sys_rst),
      .tick    (tick),
      .restart (new_value),
      .expired (no_value_exp)
   );

   // a minute plus one tick gives the strict "longer than"
   sec_timer #(.LIMIT(status_fmt_pkg::STATIC_SEC + 1)) u_static (
      .clk     (clk),
      .sys_rst (sys_rst),
      .tick    (tick),
      .restart (!static_cond),
      .expired (static_exp)
   );

   function automatic logic [2:0] eighth_code(
      input logic [FILL_W-1:0] n,
      input logic [FILL_W-1:0] cap
   );
      logic [FILL_W+3:0] n8;
      logic [2:0]        k;
      n8 = (FILL_W+4)'({n, 3'b000});
      k  = 3'h0;
      for (int i = 1; i < 8; i++) begin
         if (n8 > (FILL_W+4)'(cap) * (FILL_W+4)'(i))
            k = 3'(i);
      end
      return k;
   endfunction : eighth_code

   // cross-multiplied so no divider is needed and no fraction is lost
   function automatic logic above_share(
      input logic [FILL_W-1:0] n,
      input logic [FILL_W-1:0] cap,
      input logic [FILL_W-1:0] pct
   );
      logic [FILL_W+7:0] lhs;
      logic [FILL_W+7:0] rhs;
      lhs = (FILL_W+8)'(n) * (FILL_W+8)'(8'h64);
      rhs = (FILL_W+8)'(cap) * (FILL_W+8)'(pct);
      return lhs > rhs;
   endfunction : above_share

   always_comb begin
      fill_code = eighth_code(fill_count, fill_capacity); // see RULE1
      count_x100 = (FILL_W+8)'(fill_count) * (FILL_W+8)'(8'h64);
      cap_x80    = (FILL_W+8)'(fill_capacity) *
                   (FILL_W+8)'(status_fmt_pkg::FILL_P80);
      cap_x66    = (FILL_W+8)'(fill_capacity) *
                   (FILL_W+8)'(status_fmt_pkg::FILL_P66);
      cap_x33    = (FILL_W+8)'(fill_capacity) *
                   (FILL_W+8)'(status_fmt_pkg::FILL_P33);
      if (tdiff_xy <= status_fmt_pkg::TDIFF_LIM0)        // see RULE10
         tdiff_code = 2'h0;
      else if (tdiff_xy <= status_fmt_pkg::TDIFF_LIM1)
         tdiff_code = 2'h1;
      else if (tdiff_xy <= status_fmt_pkg::TDIFF_LIM2)
         tdiff_code = 2'h2;
      else
         tdiff_code = 2'h3;
      // exactly 33% and a zero capacity fall into the lowest band
      if (fill_capacity == '0)                            // see RULE11
         band_code = 2'h3;
      else if (above_share(fill_count, fill_capacity,
                           status_fmt_pkg::FILL_P80))
         band_code = 2'h0;
      else if (above_share(fill_count, fill_capacity,
                           status_fmt_pkg::FILL_P66))
         band_code = 2'h1;
      else if (above_share(fill_count, fill_capacity,
                           status_fmt_pkg::FILL_P33))
         band_code = 2'h2;
      else
         band_code = 2'h3;
      // choose criterion by averaging time
      if (averaging_time_param < 8'(status_fmt_pkg::AVG_THRESH_SEC))
         gen_fault = no_value_exp;                        // see RULE5 RULE13
      else
         gen_fault = ({fill_count, 1'b0} <               // see RULE6 RULE13
                      {1'b0, averaging_time_param});
      static_cond = virtual_temperature_bad || no_value_exp; // see RULE7
   end

   always_comb begin
      next_status       = status;
      next_status_valid = 1'b0;
      if (form_telegram) begin                            // see RULE14
         next_status_valid = 1'b1;
         next_status.op_status = status_fmt_pkg::BYTE_RESET; // see RULE2
         next_status.op_status[status_fmt_pkg::OP_FILL_LSB +: 3] = fill_code;
         next_status.op_status[status_fmt_pkg::OP_CRIT_BIT] =
            heat_criterion;                               // see RULE3
         next_status.op_status[status_fmt_pkg::OP_HEAT_BIT] =
            heat_on;                                      // see RULE4
         next_status.err_status = status_fmt_pkg::BYTE_RESET; // see RULE8
         next_status.err_status[status_fmt_pkg::ERR_GEN_BIT]  = gen_fault;
         next_status.err_status[status_fmt_pkg::ERR_STAT_BIT] = static_exp;
         next_status.t9_status = status_fmt_pkg::T9_RESET; // see RULE12
         next_status.t9_status[status_fmt_pkg::T9_INVAL_BIT] =
            !data_valid;                                  // see RULE9
         next_status.t9_status[status_fmt_pkg::T9_TDIFF_LSB +: 2] = tdiff_code;
         next_status.t9_status[status_fmt_pkg::T9_FILL_LSB +: 2]  = band_code;
         next_status.t9_status[status_fmt_pkg::T9_HEAT_BIT] = heat_on;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status.op_status  <= status_fmt_pkg::BYTE_RESET;
         status.err_status <= status_fmt_pkg::BYTE_RESET;
         status.t9_status  <= status_fmt_pkg::T9_RESET;
         status_valid      <= 1'b0;
      end else begin
         status       <= next_status;
         status_valid <= next_status_valid;
      end
   end

   sequence s_form;
      form_telegram;
   endsequence

   AST_OP_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
      status.op_status[0] == 1'b0 && status.op_status[4] == 1'b0 &&
      status.op_status[7] == 1'b0) // see RULE2
      else $error("operating reserved bit set");
   AST_ERR_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
      status.err_status[7:2] == 6'h00) // see RULE8
      else $error("error reserved bits set");
   AST_T9_FIXED: assert property (@(posedge clk) disable iff (sys_rst)
      status.t9_status[6:5] == 2'b10) // see RULE12
      else $error("telegram 9 fixed bits wrong");
   AST_HEAT: assert property (@(posedge clk) disable iff (sys_rst)
      s_form |=> status.op_status[6] == $past(heat_on) &&
                 status.t9_status[7] == $past(heat_on)) // see RULE4
      else $error("heating on not captured");
   AST_CRIT: assert property (@(posedge clk) disable iff (sys_rst)
      s_form |=> status.op_status[5] == $past(heat_criterion)) // see RULE3
      else $error("heating criterion not captured");
   AST_INVAL: assert property (@(posedge clk) disable iff (sys_rst)
      s_form |=> status.t9_status[0] == !$past(data_valid)) // see RULE9
      else $error("validity bit wrong");
   AST_FULL: assert property (@(posedge clk) disable iff (sys_rst)
      (s_form and (fill_count == fill_capacity && fill_capacity != '0))
      |=> status.op_status[3:1] == 3'h7 &&
          status.t9_status[4:3] == 2'h0) // see RULE1
      else $error("full buffer not coded");
   AST_TDIFF: assert property (@(posedge clk) disable iff (sys_rst)
      (s_form and (tdiff_xy > status_fmt_pkg::TDIFF_LIM2))
      |=> status.t9_status[2:1] == 2'h3) // see RULE10
      else $error("large temperature difference not coded");
   AST_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
      !form_telegram |=> $stable(status) && !status_valid) // see RULE14
      else $error("status changed without strobe");
   AST_HALF: assert property (@(posedge clk) disable iff (sys_rst)
      (s_form and (averaging_time_param >= 8'h0a &&
                   {fill_count, 1'b0} < {1'b0, averaging_time_param}))
      |=> status.err_status[0]) // see RULE6
      else $error("half buffer fault missed");

   sequence s_short_avg;
      averaging_time_param < 8'(status_fmt_pkg::AVG_THRESH_SEC);
   endsequence

   sequence s_fresh;
      $past(new_value);
   endsequence

   sequence s_cause_gone;
      !$past(virtual_temperature_bad) && !$past(no_value_exp);
   endsequence

   sequence s_banded;
      form_telegram && fill_capacity != '0;
   endsequence

   AST_VALID: assert property (@(posedge clk) disable iff (sys_rst)
      s_form |=> status_valid) // see RULE14
      else $error("no valid pulse after strobe");

   AST_VALID_CAUSE: assert property (@(posedge clk) disable iff (sys_rst)
      status_valid |-> $past(form_telegram)) // see RULE14
      else $error("valid pulse without strobe");

   AST_TD_LOW: assert property (@(posedge clk) disable iff (sys_rst)
      (s_form and (tdiff_xy <= status_fmt_pkg::TDIFF_LIM0))
      |=> status.t9_status[2:1] == 2'h0) // see RULE10
      else $error("small temperature difference not coded");

   AST_TD_MID: assert property (@(posedge clk) disable iff (sys_rst)
      (s_form and (tdiff_xy > status_fmt_pkg::TDIFF_LIM0 &&
                   tdiff_xy <= status_fmt_pkg::TDIFF_LIM1))
      |=> status.t9_status[2:1] == 2'h1) // see RULE10
      else $error("middle temperature difference not coded");

   AST_TD_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
      (s_form and (tdiff_xy > status_fmt_pkg::TDIFF_LIM1 &&
                   tdiff_xy <= status_fmt_pkg::TDIFF_LIM2))
      |=> status.t9_status[2:1] == 2'h2) // see RULE10
      else $error("upper temperature difference not coded");

   AST_BAND_UPPER: assert property (@(posedge clk) disable iff (sys_rst)
      (s_banded and (count_x100 > cap_x66 && count_x100 <= cap_x80))
      |=> status.t9_status[4:3] == 2'h1) // see RULE11
      else $error("upper middle fill band not coded");

   AST_BAND_LOWER: assert property (@(posedge clk) disable iff (sys_rst)
      (s_banded and (count_x100 > cap_x33 && count_x100 <= cap_x66))
      |=> status.t9_status[4:3] == 2'h2) // see RULE11
      else $error("lower middle fill band not coded");

   AST_BAND_LOW: assert property (@(posedge clk) disable iff (sys_rst)
      (s_banded and (count_x100 <= cap_x33))
      |=> status.t9_status[4:3] == 2'h3) // see RULE11
      else $error("low fill band not coded");

   AST_EMPTY: assert property (@(posedge clk) disable iff (sys_rst)
      (s_banded and (fill_count == '0))
      |=> status.op_status[3:1] == 3'h0 &&
          status.t9_status[4:3] == 2'h3) // see RULE1 RULE11
      else $error("empty buffer not coded");

   AST_HALF_FILL: assert property (@(posedge clk) disable iff (sys_rst)
      (s_banded and ({fill_count, 1'b0} == {1'b0, fill_capacity}))
      |=> status.op_status[3:1] == 3'h3) // see RULE1
      else $error("half full buffer not coded");

   AST_FRESH: assert property (@(posedge clk) disable iff (sys_rst)
      (s_form and s_fresh and s_short_avg)
      |=> !status.err_status[0]) // see RULE5 RULE13
      else $error("timeout shown despite new value");

   AST_STATIC_CLR: assert property (@(posedge clk) disable iff (sys_rst)
      (s_form and s_cause_gone)
      |=> !status.err_status[1]) // see RULE7
      else $error("static fault shown without cause");

   AST_HALF_MET: assert property (@(posedge clk) disable iff (sys_rst)
      (s_form and (averaging_time_param >= 8'h0a &&
                   {fill_count, 1'b0} >= {1'b0, averaging_time_param}))
      |=> !status.err_status[0]) // see RULE6 RULE13
      else $error("half buffer fault without cause");

   AST_TICK: assert property (@(posedge clk) disable iff (sys_rst)
      tick |=> !tick) // see RULE5
      else $error("second tick longer than one cycle");
endmodule : status_byte_formatter

//--- core/status_fmt_pkg.sv
package status_fmt_pkg;

   localparam int CLK_MHZ           = 250;
   localparam int TIMEOUT_SEC       = 10;
   localparam int STATIC_SEC        = 60;
   localparam int AVG_THRESH_SEC    = 10;
   localparam int TICK_NS           = 1000000000;
   localparam int TICK_CYCLES       = TICK_NS / 1000 * CLK_MHZ;

   localparam int FILL_W            = 8;
   localparam int TEMP_W            = 8;

   // temperature difference in tenths of a kelvin
   localparam logic [TEMP_W-1:0] TDIFF_LIM0 = 8'h1f;
   localparam logic [TEMP_W-1:0] TDIFF_LIM1 = 8'h3f;
   localparam logic [TEMP_W-1:0] TDIFF_LIM2 = 8'h4f;

   // fill level limits in percent
   localparam logic [FILL_W-1:0] FILL_P80 = 8'h50;
   localparam logic [FILL_W-1:0] FILL_P66 = 8'h42;
   localparam logic [FILL_W-1:0] FILL_P33 = 8'h21;

   localparam int OP_FILL_LSB       = 1;
   localparam int OP_CRIT_BIT       = 5;
   localparam int OP_HEAT_BIT       = 6;
   localparam int ERR_GEN_BIT       = 0;
   localparam int ERR_STAT_BIT      = 1;
   localparam int T9_INVAL_BIT      = 0;
   localparam int T9_TDIFF_LSB      = 1;
   localparam int T9_FILL_LSB       = 3;
   localparam int T9_ONE_BIT        = 6;
   localparam int T9_HEAT_BIT       = 7;

   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] T9_RESET   = 8'h40;

   typedef struct packed {
      logic [7:0] op_status;
      logic [7:0] err_status;
      logic [7:0] t9_status;
   } status_bytes_t;

endpackage : status_fmt_pkg
